/* File: rtl/sar_adc_defines.svh */
// timing constants and codes for the conversion control block
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH
`define CLK_PERIOD_PS 5000
`define CONV_TIME_NS 3400
`define BUSY_LOW_NS 3500
`define DATA_TO_BUSY_NS 35
`define RETRIG_WINDOW_NS 250
`define CONV_CYCLES (((`CONV_TIME_NS * 1000) / `CLK_PERIOD_PS))
`define BUSY_CYCLES (((`BUSY_LOW_NS * 1000) / `CLK_PERIOD_PS))
`define DATA_LEAD_CYCLES ((`DATA_TO_BUSY_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RETRIG_CYCLES ((`RETRIG_WINDOW_NS * 1000) / `CLK_PERIOD_PS)
`define RESULT_BITS 16
`define STEP_CYCLES (`CONV_CYCLES / `RESULT_BITS)
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define ZERO_CODE 16'h0000
`endif

/* File: rtl/sar_adc_pkg.sv */
// types for the conversion control block
package sar_adc_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_DONE = 2'b11,
		ST_WAIT = 2'b10
	} conv_state_type;
endpackage : sar_adc_pkg

/* File: rtl/result_fifo.sv */
// small synchronous fifo carrying conversion results
`timescale 1ns/100ps
`default_nettype none
module result_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// write side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// read side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic do_wr;
	logic do_rd;

	// handshakes
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	// storage
	always_ff @(posedge core_clk) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge core_clk) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr <= wr_ptr + AW'(1);
			end
			if (do_rd) begin
				rd_ptr <= rd_ptr + AW'(1);
			end
			count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
endmodule : result_fifo
`default_nettype wire

/* File: rtl/sar_adc_conversion_control.sv */
// conversion sequencing, busy timing and result bus control of the sampling converter
//
// How it works
// - select falling edge puts track/hold into hold and starts conversion.
// - after conversion track/hold returns to sample and acquires input.
// - during conversion result bus is released and busy_n stays low.
// - result driven onto bus at least 25 ns before busy_n rises.
// - idle or finishing, bus driven when read high and select low.
// - read/convert falling with chip select low also starts conversion.
// - both selects low 250 ns after busy rise retrigger a conversion.
// - chip select high early keeps outputs off; read later.
// - read/convert left low; result shown once read high, select low.
// - busy_n low from start to completion, about 3.5 us.
// - start conditions during a conversion are ignored.
// - result in two's complement, 7FFF top, 8000 bottom.
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_defines.svh"
module sar_adc_conversion_control (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// select pins from the controller
	input wire logic chip_select_n,
	input wire logic read_convert,
	// comparator decision from the analog array, one per step
	input wire logic comparator_high,
	// track/hold control and dac trial word to the analog front end
	output logic track_hold_hold,
	output logic [`RESULT_BITS-1:0] dac_trial,
	// busy flag and tri-state result bus
	output logic busy_n,
	output logic [`RESULT_BITS-1:0] result_bus_out,
	output logic result_bus_oe_n,
	// buffered result stream for on-chip consumers
	output logic stream_valid,
	input wire logic stream_ready,
	output logic [`RESULT_BITS-1:0] stream_data,
	output logic stream_overflow
);
	import sar_adc_pkg::*;

	localparam int STEP_W = 16;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic cs_meta;
	logic cs_sync;
	logic rc_meta;
	logic rc_sync;
	logic cs_prev;
	logic rc_prev;
	logic start_req;
	logic both_low;

	// two flops on each pin
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cs_meta <= 1'b1;
			cs_sync <= 1'b1;
			rc_meta <= 1'b1;
			rc_sync <= 1'b1;
		end else begin
			cs_meta <= chip_select_n;
			cs_sync <= cs_meta;
			rc_meta <= read_convert;
			rc_sync <= rc_meta;
		end
	end

	// previous sampled levels for edge detection
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cs_prev <= 1'b1;
			rc_prev <= 1'b1;
		end else begin
			cs_prev <= cs_sync;
			rc_prev <= rc_sync;
		end
	end

	assign both_low = !cs_sync && !rc_sync;
	// start on either falling edge that leaves both selects low
	assign start_req = both_low && (cs_prev || rc_prev);

	// ----------------------------------------
	// conversion sequencer
	// ----------------------------------------
	conv_state_type state;
	conv_state_type next_state;
	logic [STEP_W-1:0] step_cnt;
	logic [STEP_W-1:0] busy_cnt;
	logic [STEP_W-1:0] retrig_cnt;
	logic [4:0] bit_idx;
	logic [`RESULT_BITS-1:0] sar_reg;
	logic [`RESULT_BITS-1:0] result_reg;
	logic step_done;
	logic conv_end;
	logic busy_end;
	logic retrig;

	// one-hot trial bit for a given step index, msb first
	function automatic logic [`RESULT_BITS-1:0] bit_mask(input logic [4:0] idx);
		bit_mask = `RESULT_BITS'(1) << (5'(`RESULT_BITS - 1) - idx);
	endfunction : bit_mask

	// finished word: decided upper bits plus last decision, msb flipped for two's complement
	function automatic logic [`RESULT_BITS-1:0] final_code(input logic [`RESULT_BITS-1:0] trial,
		input logic last_high);
		final_code = {trial[`RESULT_BITS-1:1], last_high} ^ {1'b1, {(`RESULT_BITS-1){1'b0}}};
	endfunction : final_code

	assign step_done = (step_cnt == STEP_W'(`STEP_CYCLES - 1));
	assign conv_end = step_done && (bit_idx == 5'(`RESULT_BITS - 1));
	assign busy_end = (busy_cnt == STEP_W'(`BUSY_CYCLES - 1));
	assign retrig = both_low && (retrig_cnt == STEP_W'(`RETRIG_CYCLES - 1));

	// next state selection
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (start_req) begin
					next_state = ST_CONV;
				end
			end
			ST_CONV: begin
				if (conv_end) begin
					next_state = ST_DONE;
				end
			end
			ST_DONE: begin
				if (busy_end) begin
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (retrig) begin
					next_state = ST_CONV;
				end else if (!both_low) begin
					next_state = ST_IDLE;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// step timer and bit index
	always_ff @(posedge core_clk) begin
		if (reset || state != ST_CONV) begin
			step_cnt <= '0;
			bit_idx <= '0;
		end else if (step_done) begin
			step_cnt <= '0;
			bit_idx <= bit_idx + 5'(1);
		end else begin
			step_cnt <= step_cnt + STEP_W'(1);
		end
	end

	// busy length counter, runs from start to busy release
	always_ff @(posedge core_clk) begin
		if (reset || state == ST_IDLE || state == ST_WAIT) begin
			busy_cnt <= '0;
		end else begin
			busy_cnt <= busy_cnt + STEP_W'(1);
		end
	end

	// window counter after busy rises
	always_ff @(posedge core_clk) begin
		if (reset || state != ST_WAIT) begin
			retrig_cnt <= '0;
		end else begin
			retrig_cnt <= retrig_cnt + STEP_W'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sar_reg <= `ZERO_CODE;
		end else if (state != ST_CONV && next_state == ST_CONV) begin
			sar_reg <= bit_mask(5'(0));
		end else if (state == ST_CONV && step_done) begin
			// keep or drop the trial bit, then try the next one
			if (!comparator_high) begin
				sar_reg <= (sar_reg & ~bit_mask(bit_idx))
					| (conv_end ? `ZERO_CODE : bit_mask(bit_idx + 5'(1)));
			end else begin
				sar_reg <= sar_reg | (conv_end ? `ZERO_CODE : bit_mask(bit_idx + 5'(1)));
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			result_reg <= `ZERO_CODE;
		end else if (state == ST_CONV && conv_end) begin
			result_reg <= final_code(sar_reg, comparator_high);
		end
	end

	assign dac_trial = sar_reg;

	// ----------------------------------------
	// pin outputs
	// ----------------------------------------

	always_ff @(posedge core_clk) begin
		if (reset) begin
			track_hold_hold <= 1'b0;
		end else begin
			track_hold_hold <= (next_state == ST_CONV);
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			busy_n <= 1'b1;
		end else begin
			busy_n <= !(next_state == ST_CONV || next_state == ST_DONE);
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			result_bus_oe_n <= 1'b1;
		end else begin
			result_bus_oe_n <= !(rc_sync && !cs_sync && (next_state == ST_IDLE || next_state == ST_WAIT
				|| (next_state == ST_DONE && state == ST_DONE)));
		end
	end

	// driven data register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			result_bus_out <= `ZERO_CODE;
		end else begin
			result_bus_out <= result_reg;
		end
	end

	// ----------------------------------------
	// result stream
	// ----------------------------------------
	logic push;
	logic fifo_in_ready;

	assign push = (state == ST_CONV) && (next_state == ST_DONE);

	// sticky flag when a result found no room
	always_ff @(posedge core_clk) begin
		if (reset) begin
			stream_overflow <= 1'b0;
		end else if (push && !fifo_in_ready) begin
			stream_overflow <= 1'b1;
		end
	end

	logic [`RESULT_BITS-1:0] push_data;
	// same word as the bus register, taken at the last decision
	assign push_data = final_code(sar_reg, comparator_high);

	result_fifo #(
		.WIDTH(`RESULT_BITS),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_fifo (
		.core_clk(core_clk),
		.reset(reset),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(push_data),
		.out_valid(stream_valid),
		.out_ready(stream_ready),
		.out_data(stream_data)
	);
endmodule : sar_adc_conversion_control
`default_nettype wire

/* File: testbench/sar_adc_conversion_control_properties.sv */
// timing checker for the conversion control block
`timescale 1ns/100ps
`default_nettype none
module sar_adc_checker (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// pins and outputs watched
	input wire logic chip_select_n,
	input wire logic read_convert,
	input wire logic track_hold_hold,
	input wire logic [15:0] dac_trial,
	input wire logic busy_n,
	input wire logic [15:0] result_bus_out,
	input wire logic result_bus_oe_n,
	input wire logic stream_overflow
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// ----------------------------------------
	// low time counter of busy_n
	// ----------------------------------------
	logic [9:0] cnt;
	always_ff @(posedge core_clk) begin
		if (reset) cnt <= 10'h000;
		else cnt <= busy_n ? 10'h000 : cnt + 10'h001;
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	start_hold_a: assert property ($fell(busy_n) |-> track_hold_hold && dac_trial == 16'h8000)
		else $error("start without hold or msb trial");
	busy_len_a: assert property ($rose(busy_n) |-> cnt == 10'h2BC)
		else $error("busy low time wrong");
	conv_len_a: assert property ($fell(track_hold_hold) |-> !busy_n && cnt == 10'h2A0)
		else $error("conversion length wrong");
	bus_off_conv_a: assert property (track_hold_hold |-> result_bus_oe_n)
		else $error("bus driven during conversion");
	data_lead_a: assert property ($rose(busy_n) && !result_bus_oe_n
		|-> $past(!result_bus_oe_n, 5) && $past(result_bus_out, 5) == result_bus_out)
		else $error("data not valid before busy rise");
	bus_on_a: assert property ((read_convert && !chip_select_n && busy_n)[*5] |-> !result_bus_oe_n)
		else $error("bus not driven on read");
	bus_off_a: assert property ((chip_select_n || !read_convert)[*5] |-> result_bus_oe_n)
		else $error("bus driven without read");
	cs_start_a: assert property (($fell(chip_select_n) && !read_convert && busy_n)
		##1 (!chip_select_n && !read_convert)[*3] |-> ##[0:2] !busy_n)
		else $error("chip select start missed");
	rc_start_a: assert property (($fell(read_convert) && !chip_select_n && busy_n)
		##1 (!chip_select_n && !read_convert)[*3] |-> ##[0:2] !busy_n)
		else $error("read convert start missed");
	c_conv: cover property ($rose(busy_n));
	c_read: cover property ($fell(result_bus_oe_n));
	c_over: cover property ($rose(stream_overflow));
	c_lead: cover property ($rose(busy_n) && !result_bus_oe_n);
endmodule : sar_adc_checker
bind sar_adc_conversion_control sar_adc_checker checker_i (.core_clk(core_clk), .reset(reset),
	.chip_select_n(chip_select_n), .read_convert(read_convert), .track_hold_hold(track_hold_hold),
	.dac_trial(dac_trial), .busy_n(busy_n), .result_bus_out(result_bus_out),
	.result_bus_oe_n(result_bus_oe_n), .stream_overflow(stream_overflow));
`default_nettype wire

/* File: testbench/host_model.sv */
// controller model driving the select pins
`timescale 1ns/100ps
`default_nettype none
module host_model (
	// clock and commands
	input wire logic core_clk,
	input wire logic start,
	input wire logic swap,
	input wire logic [11:0] hold,
	input wire logic rd,
	// select pins
	output logic chip_select_n,
	output logic read_convert
);
	logic act = 1'b0;
	logic cs_i = 1'b1;
	logic rc_i = 1'b1;
	// idle pins show a read request or nothing
	assign chip_select_n = act ? cs_i : !rd;
	assign read_convert = act ? rc_i : 1'b1;
	always @(posedge start) begin
		act = 1'b1;
		@(negedge core_clk);
		if (swap) begin
			cs_i = 1'b0;
			repeat (8) @(negedge core_clk);
			rc_i = 1'b0;
		end else begin
			rc_i = 1'b0;
			repeat (20) @(negedge core_clk);
			cs_i = 1'b0;
		end
		repeat (hold) @(negedge core_clk);
		cs_i = 1'b1;
		rc_i = 1'b1;
		@(negedge core_clk);
		act = 1'b0;
	end
endmodule : host_model
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the conversion control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import sar_adc_pkg::*;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic comparator_high = 1'b0;
	logic stream_ready = 1'b1;
	logic start = 1'b0;
	logic swap = 1'b0;
	logic rd = 1'b0;
	logic [11:0] hold = 12'h00A;
	logic [15:0] target = 16'h0000;
	wire logic chip_select_n, read_convert, track_hold_hold, busy_n, result_bus_oe_n, stream_valid, stream_overflow;
	wire logic [15:0] dac_trial, result_bus_out, stream_data;
	int bad_count = 0;
	int checked = 0;
	int i;
	logic [15:0] q[$];
	always #2.5 core_clk = ~core_clk;
	// ----------------------------------------
	// partner, analog comparator and design
	// ----------------------------------------
	host_model host (.core_clk(core_clk), .start(start), .swap(swap), .hold(hold), .rd(rd),
		.chip_select_n(chip_select_n), .read_convert(read_convert));
	always @(negedge core_clk) comparator_high <= (dac_trial <= target);
	sar_adc_conversion_control dut (.core_clk(core_clk), .reset(reset), .chip_select_n(chip_select_n),
		.read_convert(read_convert), .comparator_high(comparator_high), .track_hold_hold(track_hold_hold),
		.dac_trial(dac_trial), .busy_n(busy_n), .result_bus_out(result_bus_out),
		.result_bus_oe_n(result_bus_oe_n), .stream_valid(stream_valid), .stream_ready(stream_ready),
		.stream_data(stream_data), .stream_overflow(stream_overflow));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task wait_busy(input logic v);
		for (int k = 0; k < 2000 && busy_n !== v; k++) @(negedge core_clk);
		chk("busy_n", {15'h0, v}, {15'h0, busy_n});
	endtask : wait_busy
	// one start, n results, then a late read of the bus
	task conv(input logic [15:0] t, input logic sw, input logic [11:0] h, input int n, input logic keep,
		input logic early);
		target = t;
		if (keep) repeat (n) q.push_back(t ^ 16'h8000);
		swap = sw;
		hold = h;
		start = 1'b1;
		@(negedge core_clk) start = 1'b0;
		// early read keeps the bus selected through the end of conversion
		rd = early;
		repeat (n) begin
			wait_busy(1'b0);
			wait_busy(1'b1);
		end
		if (early) begin
			chk("latch_oe_n", 16'h0, {15'h0, result_bus_oe_n});
			chk("latched", t ^ 16'h8000, result_bus_out);
		end
		repeat (10) @(negedge core_clk);
		rd = 1'b1;
		repeat (6) @(negedge core_clk);
		chk("oe_n", 16'h0, {15'h0, result_bus_oe_n});
		chk("result_bus", t ^ 16'h8000, result_bus_out);
		rd = 1'b0;
		repeat (100) @(negedge core_clk);
	endtask : conv
	task finish_test;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	// stream monitor compares each result with the oldest note
	always @(posedge core_clk) begin
		if (stream_valid === 1'b1 && stream_ready)
			chk("stream_data", q.size() ? q.pop_front() : ~stream_data, stream_data);
	end
	// ----------------------------------------
	// test sequence and watchdog
	// ----------------------------------------
	initial begin
		void'($urandom(32'h3A8FB111));
		repeat (20) @(posedge core_clk);
		@(negedge core_clk) reset = 1'b0;
		for (i = 0; i < 4; i++) conv(i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : i == 2 ? 16'h8000 : 16'($urandom),
			i[0], 12'h00A, 1, 1'b1, i == 2);
		$display("test codes done");
		conv(16'($urandom), 1'b0, 12'h2F8, 2, 1'b1, 1'b0);
		$display("test retrigger done");
		stream_ready = 1'b0;
		for (i = 0; i < 17; i++) conv(16'($urandom), 1'b0, 12'h00A, 1, i < 16, 1'b0);
		chk("overflow", 16'h1, {15'h0, stream_overflow});
		for (i = 0; i < 200; i++) @(negedge core_clk) stream_ready = 1'($urandom);
		stream_ready = 1'b1;
		repeat (10) @(negedge core_clk);
		chk("left", 16'h0, 16'(q.size()));
		$display("test buffer done");
		finish_test();
	end
	initial begin
		repeat (60000) @(posedge core_clk);
		bad_count++;
		finish_test();
	end
endmodule : testbench
`default_nettype wire
